// >>> design/esc_pkg.sv
// shared constants and types for the event status capture bank
package esc_pkg;

  // ------------------------------------------------------------
  // register offsets (7-bit register address)
  // ------------------------------------------------------------
  localparam logic [6:0] ESC_SYS_CAPT_EN_OFS   = 7'h04;
  localparam logic [6:0] ESC_GLOBAL_SUM_OFS    = 7'h60;
  localparam logic [6:0] ESC_CAN_TRX_FLAGS_OFS = 7'h63;
  localparam logic [6:0] ESC_WAKE_FLAGS_OFS    = 7'h64;
  localparam logic [6:0] ESC_BUS_FLAGS_OFS     = 7'h65;
  localparam logic [6:0] ESC_REG_FLAGS_OFS     = 7'h66;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  // can transceiver event flags
  localparam int ESC_CAN_OVERTEMP_BIT = 2;
  localparam int ESC_TRX_FAIL_BIT     = 1;
  localparam int ESC_CAN_WAKE_BIT     = 0;
  localparam int ESC_CAN_W            = 3;
  // wake event flags
  localparam int ESC_EXT_WAKE_BIT     = 2;
  localparam int ESC_RISE_WAKE_BIT    = 1;
  localparam int ESC_FALL_WAKE_BIT    = 0;
  localparam int ESC_WAKE_W           = 3;
  // bus failure flags
  localparam int ESC_BUS_TIMEOUT_BIT  = 1;
  localparam int ESC_BUS_SHORT_BIT    = 0;
  localparam int ESC_BUS_W            = 2;
  // regulator event flags
  localparam int ESC_MAIN_OT_BIT      = 7;
  localparam int ESC_MAIN_PW_BIT      = 6;
  localparam int ESC_MAIN_OV_BIT      = 5;
  localparam int ESC_MAIN_UV_BIT      = 4;
  localparam int ESC_SENS_OT_BIT      = 3;
  localparam int ESC_SENS_PW_BIT      = 2;
  localparam int ESC_SENS_OV_BIT      = 1;
  localparam int ESC_SENS_UV_BIT      = 0;
  localparam int ESC_REG_W            = 8;
  // system capture enable
  localparam int ESC_BATT_UV_EN_BIT   = 6;
  localparam int ESC_IO_UV_EN_BIT     = 3;
  localparam int ESC_PREWARN_EN_BIT   = 2;
  localparam int ESC_SPI_FAIL_EN_BIT  = 1;
  localparam int ESC_RST_SEL_BIT      = 0;
  localparam logic [7:0] ESC_SYS_CAPT_EN_MASK = 8'h4f;
  // global summary group positions
  localparam int ESC_SUM_BUS_BIT      = 5;
  localparam int ESC_SUM_WAKE_BIT     = 4 - 1;
  localparam int ESC_SUM_CAN_BIT      = 2;
  localparam int ESC_SUM_REG_BIT      = 1;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] ESC_SYS_CAPT_EN_RST = 8'h01;
  localparam logic [7:0] ESC_FLAGS_RST       = 8'h00;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int ESC_CLK_KHZ        = 10000;
  localparam int ESC_SENS_OV_DEB_US = 20;
  localparam int ESC_SENS_UV_DEB_US = 20;
  localparam int ESC_SENS_OV_DEB_CYC = (ESC_SENS_OV_DEB_US * ESC_CLK_KHZ + 999) / 1000;
  localparam int ESC_SENS_UV_DEB_CYC = (ESC_SENS_UV_DEB_US * ESC_CLK_KHZ + 999) / 1000;
  localparam int ESC_DEB_CNT_W      = 16;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ESC_CAN_OFFLINE,
    ESC_CAN_NORMAL,
    ESC_CAN_REDUCED,
    ESC_CAN_SILENT
  } esc_can_mode_t;

endpackage

// >>> design/esc_flag_if.sv
// set, clear and state lines of one bank of sticky event flags
`timescale 1ns/1ps
interface esc_flag_if #(
  parameter int W = 8
);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] flag;

  modport bank (
    input  set,
    input  clr,
    output flag
  );

  modport ctl (
    output set,
    output clr,
    input  flag
  );
endinterface

// >>> design/esc_flag_bank.sv
// one bank of write-one-to-clear sticky event flags
`timescale 1ns/1ps
module esc_flag_bank #(
  parameter int           W         = 8,
  parameter logic [W-1:0] SLEEP_CLR = '0
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic sleep_clr_i,
  esc_flag_if.bank  fl
);
  import esc_pkg::*;

  logic [W-1:0] flag_reg;
  logic [W-1:0] flag_next;
  logic [W-1:0] kill;

  // a set in the clear cycle wins, so no event is lost
  always_comb
  begin
    kill      = fl.clr | (sleep_clr_i ? SLEEP_CLR : '0);
    flag_next = (flag_reg & ~kill) | fl.set;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_reg <= ESC_FLAGS_RST[W-1:0];
    else
      flag_reg <= flag_next;
  end

  assign fl.flag = flag_reg;
endmodule

// >>> design/esc_debounce.sv
// persistence filter: output rises once input held for CYC cycles
`timescale 1ns/1ps
module esc_debounce #(
  parameter int CYC = 200
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic level_i,
  output logic      held_o
);
  import esc_pkg::*;

  localparam logic [ESC_DEB_CNT_W-1:0] LIMIT = ESC_DEB_CNT_W'(CYC);

  logic [ESC_DEB_CNT_W-1:0] cnt_reg;
  logic [ESC_DEB_CNT_W-1:0] cnt_next;
  logic                     held_reg;
  logic                     held_next;

  // any drop restarts the count; a glitch never reaches the flag
  always_comb
  begin
    cnt_next  = cnt_reg;
    held_next = 1'b0;
    if (!level_i)
      cnt_next = '0;
    else if (cnt_reg < LIMIT)
      cnt_next = cnt_reg + 1'b1;
    if (level_i && (cnt_reg >= LIMIT))
      held_next = 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg  <= '0;
      held_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      held_reg <= held_next;
    end
  end

  assign held_o = held_reg;
endmodule

// >>> design/esc_event_bank.sv
// event status capture bank: sticky event flags, capture enables, readback
`timescale 1ns/1ps
module esc_event_bank (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // register access from the serial port decoder
  input  wire logic [6:0]            reg_addr_i,
  input  wire logic [7:0]            reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic [7:0]                 reg_rdata_o,
  // device state from on-chip logic
  input  wire esc_pkg::esc_can_mode_t can_mode_i,
  input  wire logic                  uv_sleep_i,
  // capture enables held in neighbouring registers
  input  wire logic                  trx_fail_en_i,
  input  wire logic                  rx_clamp_en_i,
  input  wire logic                  can_wake_en_i,
  input  wire logic                  ext_wake_en_i,
  input  wire logic                  rise_wake_en_i,
  input  wire logic                  fall_wake_en_i,
  input  wire logic                  main_ov_en_i,
  input  wire logic                  main_uv_en_i,
  input  wire logic                  sens_ov_en_i,
  input  wire logic                  sens_uv_en_i,
  // raw detector levels, asynchronous to clk_i
  input  wire logic                  can_overtemp_i,
  input  wire logic                  txd_clamp_i,
  input  wire logic                  vcc_uv_trx_i,
  input  wire logic                  rxd_rec_clamp_i,
  input  wire logic                  can_wake_i,
  input  wire logic                  lin2_wake_i,
  input  wire logic                  wake_pin_i,
  input  wire logic                  bus_dom_timeout_i,
  input  wire logic                  bus_short_i,
  input  wire logic                  main_reg_ot_i,
  input  wire logic                  main_reg_pw_i,
  input  wire logic                  main_ov_i,
  input  wire logic                  main_uv_i,
  input  wire logic                  sens_reg_ot_i,
  input  wire logic                  sens_reg_pw_i,
  input  wire logic                  sens_ov_i,
  input  wire logic                  sens_uv_i,
  // outputs to the rest of the chip
  output logic [7:0]                 global_summary_o,
  output logic                       sensor_reg_disable_o,
  output logic                       battery_undervolt_capture_en_o,
  output logic                       io_undervolt_capture_en_o,
  output logic                       prewarn_capture_en_o,
  output logic                       serial_fail_detect_en_o,
  output logic                       reset_threshold_select_o
);
  import esc_pkg::*;

  localparam int RAW_W = 17;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [RAW_W-1:0] raw;
  logic [RAW_W-1:0] sync1_reg;
  logic [RAW_W-1:0] sync2_reg;
  logic [RAW_W-1:0] sync1_next;
  logic [RAW_W-1:0] sync2_next;
  logic             wake_prev_reg;
  logic             wake_prev_next;

  // gather every detector level so one synchroniser covers them
  assign raw = {can_overtemp_i, txd_clamp_i, vcc_uv_trx_i, rxd_rec_clamp_i,
                can_wake_i, lin2_wake_i, wake_pin_i, bus_dom_timeout_i,
                bus_short_i, main_reg_ot_i, main_reg_pw_i, main_ov_i,
                main_uv_i, sens_reg_ot_i, sens_reg_pw_i, sens_ov_i, sens_uv_i};

  // first stage feeds only the second; edge logic looks at stage two
  always_comb
  begin
    sync1_next     = raw;
    sync2_next     = sync1_reg;
    wake_prev_next = sync2_reg[10];
  end

  // stages run through reset so the edge detector starts at the pin level:
  // a pin already high at release gives no false rising edge
  always_ff @(posedge clk_i)
  begin
    sync1_reg     <= sync1_next;
    sync2_reg     <= sync2_next;
    wake_prev_reg <= wake_prev_next;
  end

  logic s_can_ot;
  logic s_txd_clamp;
  logic s_vcc_uv;
  logic s_rxd_clamp;
  logic s_can_wake;
  logic s_lin2_wake;
  logic s_wake_pin;
  logic s_bus_to;
  logic s_bus_short;
  logic s_main_ot;
  logic s_main_pw;
  logic s_main_ov;
  logic s_main_uv;
  logic s_sens_ot;
  logic s_sens_pw;
  logic s_sens_ov;
  logic s_sens_uv;

  // named views of the synchronised levels
  assign {s_can_ot, s_txd_clamp, s_vcc_uv, s_rxd_clamp, s_can_wake,
          s_lin2_wake, s_wake_pin, s_bus_to, s_bus_short, s_main_ot,
          s_main_pw, s_main_ov, s_main_uv, s_sens_ot, s_sens_pw,
          s_sens_ov, s_sens_uv} = sync2_reg;

  // ------------------------------------------------------------
  // sensor supply persistence filters
  // ------------------------------------------------------------
  logic sens_ov_held;
  logic sens_uv_held;

  esc_debounce #(
    .CYC (ESC_SENS_OV_DEB_CYC)
  ) u_sens_ov_deb (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i (s_sens_ov),
    .held_o  (sens_ov_held)
  );

  esc_debounce #(
    .CYC (ESC_SENS_UV_DEB_CYC)
  ) u_sens_uv_deb (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i (s_sens_uv),
    .held_o  (sens_uv_held)
  );

  // ------------------------------------------------------------
  // system capture enable register
  // ------------------------------------------------------------
  logic [7:0] sys_capt_en_reg;
  logic [7:0] sys_capt_en_next;
  logic       prewarn_en;

  // reserved bits are masked off so they always read zero
  always_comb
  begin
    sys_capt_en_next = sys_capt_en_reg;
    if (reg_wr_i && (reg_addr_i == ESC_SYS_CAPT_EN_OFS))
      sys_capt_en_next = reg_wdata_i & ESC_SYS_CAPT_EN_MASK;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sys_capt_en_reg <= ESC_SYS_CAPT_EN_RST;
    else
      sys_capt_en_reg <= sys_capt_en_next;
  end

  assign prewarn_en = sys_capt_en_reg[ESC_PREWARN_EN_BIT];

  // enables leave as plain levels for the owning functions
  assign battery_undervolt_capture_en_o = sys_capt_en_reg[ESC_BATT_UV_EN_BIT];
  assign io_undervolt_capture_en_o      = sys_capt_en_reg[ESC_IO_UV_EN_BIT];
  assign prewarn_capture_en_o           = prewarn_en;
  assign serial_fail_detect_en_o        = sys_capt_en_reg[ESC_SPI_FAIL_EN_BIT];
  // one picks transceiver-level vcc uv, zero the io-level threshold
  assign reset_threshold_select_o       = sys_capt_en_reg[ESC_RST_SEL_BIT];

  // ------------------------------------------------------------
  // event flag banks
  // ------------------------------------------------------------
  esc_flag_if #(.W(ESC_CAN_W))  can_fl ();
  esc_flag_if #(.W(ESC_WAKE_W)) wake_fl ();
  esc_flag_if #(.W(ESC_BUS_W))  bus_fl ();
  esc_flag_if #(.W(ESC_REG_W))  reg_fl ();

  logic wr_can;
  logic wr_wake;
  logic wr_bus;
  logic wr_reg;

  // write-one clears, decoded per bank; zeros clear nothing
  assign wr_can  = reg_wr_i && (reg_addr_i == ESC_CAN_TRX_FLAGS_OFS);
  assign wr_wake = reg_wr_i && (reg_addr_i == ESC_WAKE_FLAGS_OFS);
  assign wr_bus  = reg_wr_i && (reg_addr_i == ESC_BUS_FLAGS_OFS);
  assign wr_reg  = reg_wr_i && (reg_addr_i == ESC_REG_FLAGS_OFS);

  assign can_fl.clr  = wr_can  ? reg_wdata_i[ESC_CAN_W-1:0]  : '0;
  assign wake_fl.clr = wr_wake ? reg_wdata_i[ESC_WAKE_W-1:0] : '0;
  assign bus_fl.clr  = wr_bus  ? reg_wdata_i[ESC_BUS_W-1:0]  : '0;
  assign reg_fl.clr  = wr_reg  ? reg_wdata_i                 : '0;

  // can transceiver failure causes, each qualified by the current can mode
  logic mode_norm;
  logic mode_norm_red;
  logic mode_rx_live;
  logic trx_cause;

  assign mode_norm     = (can_mode_i == ESC_CAN_NORMAL);
  assign mode_norm_red = mode_norm || (can_mode_i == ESC_CAN_REDUCED);
  assign mode_rx_live  = mode_norm_red || (can_mode_i == ESC_CAN_SILENT);

  assign trx_cause = (s_txd_clamp && mode_norm)
                  || (s_vcc_uv && mode_norm_red)
                  || (s_rxd_clamp && rx_clamp_en_i && mode_rx_live);

  assign can_fl.set[ESC_CAN_OVERTEMP_BIT] = s_can_ot;
  assign can_fl.set[ESC_TRX_FAIL_BIT]     = trx_fail_en_i && trx_cause;
  assign can_fl.set[ESC_CAN_WAKE_BIT]     = can_wake_en_i && s_can_wake;

  // wake pin edges come from the synchronised level only
  assign wake_fl.set[ESC_EXT_WAKE_BIT]  = ext_wake_en_i && s_lin2_wake;
  assign wake_fl.set[ESC_RISE_WAKE_BIT] = rise_wake_en_i
                                        && s_wake_pin && !wake_prev_reg;
  assign wake_fl.set[ESC_FALL_WAKE_BIT] = fall_wake_en_i
                                        && !s_wake_pin && wake_prev_reg;

  assign bus_fl.set[ESC_BUS_TIMEOUT_BIT] = s_bus_to;
  assign bus_fl.set[ESC_BUS_SHORT_BIT]   = s_bus_short;

  assign reg_fl.set[ESC_MAIN_OT_BIT] = s_main_ot;
  assign reg_fl.set[ESC_MAIN_PW_BIT] = prewarn_en && s_main_pw;
  assign reg_fl.set[ESC_MAIN_OV_BIT] = main_ov_en_i && s_main_ov;
  assign reg_fl.set[ESC_MAIN_UV_BIT] = main_uv_en_i && s_main_uv;
  assign reg_fl.set[ESC_SENS_OT_BIT] = s_sens_ot;
  assign reg_fl.set[ESC_SENS_PW_BIT] = prewarn_en && s_sens_pw;
  assign reg_fl.set[ESC_SENS_OV_BIT] = sens_ov_en_i && sens_ov_held;
  assign reg_fl.set[ESC_SENS_UV_BIT] = sens_uv_en_i && sens_uv_held;

  // uv forced sleep wipes only the failure and local wake flags
  localparam logic [ESC_CAN_W-1:0] CAN_SLEEP_CLR =
    ESC_CAN_W'(1 << ESC_TRX_FAIL_BIT);
  localparam logic [ESC_WAKE_W-1:0] WAKE_SLEEP_CLR =
    ESC_WAKE_W'((1 << ESC_RISE_WAKE_BIT) | (1 << ESC_FALL_WAKE_BIT));

  esc_flag_bank #(
    .W         (ESC_CAN_W),
    .SLEEP_CLR (CAN_SLEEP_CLR)
  ) u_can_flags (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .sleep_clr_i (uv_sleep_i),
    .fl          (can_fl.bank)
  );

  esc_flag_bank #(
    .W         (ESC_WAKE_W),
    .SLEEP_CLR (WAKE_SLEEP_CLR)
  ) u_wake_flags (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .sleep_clr_i (uv_sleep_i),
    .fl          (wake_fl.bank)
  );

  esc_flag_bank #(
    .W         (ESC_BUS_W),
    .SLEEP_CLR ('0)
  ) u_bus_flags (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .sleep_clr_i (uv_sleep_i),
    .fl          (bus_fl.bank)
  );

  esc_flag_bank #(
    .W         (ESC_REG_W),
    .SLEEP_CLR ('0)
  ) u_reg_flags (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .sleep_clr_i (uv_sleep_i),
    .fl          (reg_fl.bank)
  );

  // sensor regulator stays off while its overvoltage flag stands
  assign sensor_reg_disable_o = reg_fl.flag[ESC_SENS_OV_BIT];

  // ------------------------------------------------------------
  // global summary
  // ------------------------------------------------------------
  logic [7:0] summary;

  // bits owned by blocks outside this bank read zero here
  always_comb
  begin
    summary                   = 8'h00;
    summary[ESC_SUM_BUS_BIT]  = |bus_fl.flag;
    summary[ESC_SUM_WAKE_BIT] = |wake_fl.flag;
    summary[ESC_SUM_CAN_BIT]  = |can_fl.flag;
    summary[ESC_SUM_REG_BIT]  = |reg_fl.flag;
  end

  assign global_summary_o = summary;

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // data registered one cycle after the read strobe, held until
  // the next read; unmapped offsets answer zero
  always_comb
  begin
    rdata_next = rdata_reg;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        ESC_SYS_CAPT_EN_OFS:   rdata_next = sys_capt_en_reg;
        ESC_GLOBAL_SUM_OFS:    rdata_next = summary;
        ESC_CAN_TRX_FLAGS_OFS: rdata_next = 8'(can_fl.flag);
        ESC_WAKE_FLAGS_OFS:    rdata_next = 8'(wake_fl.flag);
        ESC_BUS_FLAGS_OFS:     rdata_next = 8'(bus_fl.flag);
        ESC_REG_FLAGS_OFS:     rdata_next = reg_fl.flag;
        default:               rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  assign reg_rdata_o = rdata_reg;
endmodule

// >>> test/esc_event_bank_assertions.sv
// port-level concurrent checks for the event status capture bank
`timescale 1ns/1ps
module esc_event_bank_assertions (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       bus_short_i,
  input wire logic       sens_ov_i,
  input wire logic [7:0] global_summary_o,
  input wire logic       sensor_reg_disable_o,
  input wire logic       prewarn_capture_en_o,
  input wire logic       reset_threshold_select_o
);
  import esc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  // raw level rises and stays long enough to cross both syncs
  sequence held_up(s);
    $rose(s) ##1 s [*2];
  endsequence
  logic       cfg_wr;
  logic [7:0] wdata_reg;
  assign cfg_wr = reg_wr_i && reg_addr_i == ESC_SYS_CAPT_EN_OFS;
  // write data bus from one cycle back, so the enables can be tied to it
  always_ff @(posedge clk_i)
    wdata_reg <= reg_wdata_i;
  // -------------------------------------------------------------
  // properties
  // -------------------------------------------------------------
  a_rst_release: assert property ($fell(rst_i) |-> reset_threshold_select_o
    && global_summary_o == 8'h00 && !sensor_reg_disable_o)
    else $error("reset values wrong");
  a_sum_resv: assert property (global_summary_o[7:6] == 2'h0
    && !global_summary_o[4] && !global_summary_o[0])
    else $error("unused summary bit set");
  a_cfg_write: assert property (cfg_wr |=> reset_threshold_select_o == wdata_reg[0]
    && prewarn_capture_en_o == wdata_reg[2])
    else $error("enable bit not written");
  a_cfg_hold: assert property (!cfg_wr |=> $stable(reset_threshold_select_o)
    && $stable(prewarn_capture_en_o))
    else $error("enable bit moved without write");
  a_read_resv: assert property (reg_rd_i && reg_addr_i == ESC_BUS_FLAGS_OFS
    |=> reg_rdata_o[7:2] == 6'h00)
    else $error("reserved bus bits read nonzero");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 7'h10
    |=> reg_rdata_o == 8'h00)
    else $error("unmapped read nonzero");
  a_bus_short: assert property (held_up(bus_short_i)
    |=> global_summary_o[ESC_SUM_BUS_BIT])
    else $error("bus short not captured");
  a_sens_off: assert property ($rose(sensor_reg_disable_o)
    |-> global_summary_o[ESC_SUM_REG_BIT] && $past(sens_ov_i, 8))
    else $error("sensor disable without held overvoltage");
endmodule
bind esc_event_bank esc_event_bank_assertions chk_u (
  .clk_i                    (clk_i),
  .rst_i                    (rst_i),
  .reg_addr_i               (reg_addr_i),
  .reg_wdata_i              (reg_wdata_i),
  .reg_wr_i                 (reg_wr_i),
  .reg_rd_i                 (reg_rd_i),
  .reg_rdata_o              (reg_rdata_o),
  .bus_short_i              (bus_short_i),
  .sens_ov_i                (sens_ov_i),
  .global_summary_o         (global_summary_o),
  .sensor_reg_disable_o     (sensor_reg_disable_o),
  .prewarn_capture_en_o     (prewarn_capture_en_o),
  .reset_threshold_select_o (reset_threshold_select_o)
);

// >>> test/esc_host_model.sv
// host side of the register port: single reads and writes
`timescale 1ns/1ps
module esc_host_model (
  input  wire logic       clk_i,
  output logic [6:0]      addr_o,
  output logic [7:0]      wdata_o,
  output logic            wr_o,
  output logic            rd_o,
  input  wire logic [7:0] rdata_i
);
  initial
  begin
    addr_o = 7'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // strobe taken at the rising edge between two falling edges
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a; // idle lines carry junk, not the last value
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
endmodule

// >>> test/esc_event_bank_tb.sv
// self-checking bench for the event status capture bank
`timescale 1ns/1ps
module esc_event_bank_tb;
  import esc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic uv_sleep_i = 1'b0;
  logic [6:0] reg_addr_i, a;
  logic [7:0] reg_wdata_i, reg_rdata_o, global_summary_o, d, e, w;
  logic reg_wr_i, reg_rd_i, sensor_reg_disable_o, battery_undervolt_capture_en_o;
  logic io_undervolt_capture_en_o, prewarn_capture_en_o;
  logic serial_fail_detect_en_o, reset_threshold_select_o;
  esc_can_mode_t can_mode_i = ESC_CAN_OFFLINE;
  logic [9:0] en = '0;
  logic [16:0] ev = '0;
  logic trx_fail_en_i, rx_clamp_en_i, can_wake_en_i, ext_wake_en_i, rise_wake_en_i;
  logic fall_wake_en_i, main_ov_en_i, main_uv_en_i, sens_ov_en_i, sens_uv_en_i;
  logic can_overtemp_i, txd_clamp_i, vcc_uv_trx_i, rxd_rec_clamp_i, can_wake_i;
  logic lin2_wake_i, wake_pin_i, bus_dom_timeout_i, bus_short_i, main_reg_ot_i;
  logic main_reg_pw_i, main_ov_i, main_uv_i, sens_reg_ot_i, sens_reg_pw_i;
  logic sens_ov_i, sens_uv_i;
  int errors = 0, tests_run = 0, cyc = 0, seed = 36074, i;
  logic [6:0] ofs [7] = '{ESC_SYS_CAPT_EN_OFS, ESC_GLOBAL_SUM_OFS, ESC_CAN_TRX_FLAGS_OFS,
    ESC_WAKE_FLAGS_OFS, ESC_BUS_FLAGS_OFS, ESC_REG_FLAGS_OFS, 7'h10};
  assign {sens_uv_en_i, sens_ov_en_i, main_uv_en_i, main_ov_en_i, fall_wake_en_i,
    rise_wake_en_i, ext_wake_en_i, can_wake_en_i, rx_clamp_en_i, trx_fail_en_i} = en;
  assign {sens_uv_i, sens_ov_i, sens_reg_pw_i, sens_reg_ot_i, main_uv_i, main_ov_i,
    main_reg_pw_i, main_reg_ot_i, bus_short_i, bus_dom_timeout_i, wake_pin_i, lin2_wake_i,
    can_wake_i, rxd_rec_clamp_i, vcc_uv_trx_i, txd_clamp_i, can_overtemp_i} = ev;
  esc_event_bank dut_u (.*);
  esc_host_model host_u (.clk_i(clk_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i),
    .wr_o(reg_wr_i), .rd_o(reg_rd_i), .rdata_i(reg_rdata_o));
  // ---------------------------------------------------------------
  // clock and hang guard, sized well above the expected run
  // ---------------------------------------------------------------
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      errors++;
      final_report();
    end
  end
  // ---------------------------------------------------------------
  // checking helpers
  // ---------------------------------------------------------------
  task automatic chk(string n, logic [7:0] x, logic [7:0] g);
    tests_run++;
    if (g !== x)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic rchk(logic [6:0] ra, logic [7:0] x);
    host_u.rd(ra, d);
    chk($sformatf("reg %h", ra), x, d);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // group register and summary bit of each detector
  function automatic logic [6:0] grp(int k);
    return k < 5 ? ESC_CAN_TRX_FLAGS_OFS : k < 7 ? ESC_WAKE_FLAGS_OFS
      : k < 9 ? ESC_BUS_FLAGS_OFS : ESC_REG_FLAGS_OFS;
  endfunction
  function automatic logic [7:0] sum_of(logic [6:0] ga, logic [7:0] f);
    int b;
    b = ga == ESC_BUS_FLAGS_OFS ? ESC_SUM_BUS_BIT : ga == ESC_WAKE_FLAGS_OFS
      ? ESC_SUM_WAKE_BIT : ga == ESC_CAN_TRX_FLAGS_OFS ? ESC_SUM_CAN_BIT : ESC_SUM_REG_BIT;
    return (f != 8'h00) ? 8'h01 << b : 8'h00;
  endfunction
  // flags one raised detector should leave behind
  function automatic logic [7:0] expect_flag(int k, logic [9:0] n, esc_can_mode_t m, logic p);
    case (k)
      0: return 8'h04;
      1: return {6'h0, n[0] & m == ESC_CAN_NORMAL, 1'b0};
      2: return {6'h0, n[0] & (m == ESC_CAN_NORMAL | m == ESC_CAN_REDUCED), 1'b0};
      3: return {6'h0, n[0] & n[1] & m != ESC_CAN_OFFLINE, 1'b0};
      4: return {7'h0, n[2]};
      5: return {5'h0, n[3], 2'h0};
      6: return {6'h0, n[4], n[5]};
      7: return 8'h02;
      8: return 8'h01;
      9: return 8'h80;
      10: return {1'b0, p, 6'h0};
      11: return {2'h0, n[6], 5'h0};
      12: return {3'h0, n[7], 4'h0};
      13: return 8'h08;
      14: return {5'h0, p, 2'h0};
      15: return {6'h0, n[8], 1'b0};
      default: return {7'h0, n[9]};
    endcase
  endfunction
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    // summary and unmapped places must shrug off writes
    host_u.wr(ESC_GLOBAL_SUM_OFS, 8'hff);
    host_u.wr(7'h10, 8'hff);
    foreach (ofs[k]) rchk(ofs[k], k == 0 ? 8'h01 : 8'h00);
    // each detector twice, enables, mode and prewarning drawn at random
    for (int r = 0; r < 34; r++)
    begin
      i = r % 17;
      // first pass opens every capture path once, second pass keeps the draws
      w = 8'($random(seed)) | (r < 17 ? 8'h04 : 8'h00);
      host_u.wr(ESC_SYS_CAPT_EN_OFS, w);
      rchk(ESC_SYS_CAPT_EN_OFS, w & ESC_SYS_CAPT_EN_MASK);
      chk("enables", {3'h0, w[6], w[3:0]}, {3'h0, battery_undervolt_capture_en_o,
        io_undervolt_capture_en_o, prewarn_capture_en_o, serial_fail_detect_en_o,
        reset_threshold_select_o});
      en = r < 17 ? '1 : 10'($random(seed));
      can_mode_i = r < 17 ? ESC_CAN_NORMAL : esc_can_mode_t'(2'($random(seed)));
      ev[i] = 1'b1;
      repeat (ESC_SENS_OV_DEB_CYC + 15) @(negedge clk_i);
      ev[i] = 1'b0;
      repeat (6) @(negedge clk_i);
      a = grp(i);
      e = expect_flag(i, en, can_mode_i, w[ESC_PREWARN_EN_BIT]);
      chk("summary", sum_of(a, e), global_summary_o);
      chk("sensor off", {7'h0, i == 15 && e != 8'h00}, {7'h0, sensor_reg_disable_o});
      rchk(a, e);
      host_u.wr(a, 8'h00);
      rchk(a, e);
      host_u.wr(a, 8'hff);
      rchk(a, 8'h00);
      chk("summary clear", 8'h00, global_summary_o);
    end
    // forced sleep wipes failure and local wake flags, not the others
    en = '1;
    can_mode_i = ESC_CAN_NORMAL;
    ev[6:1] = 6'h31;
    repeat (8) @(negedge clk_i);
    ev = '0;
    repeat (6) @(negedge clk_i);
    rchk(ESC_WAKE_FLAGS_OFS, 8'h07);
    rchk(ESC_CAN_TRX_FLAGS_OFS, 8'h02);
    uv_sleep_i = 1'b1;
    @(negedge clk_i);
    uv_sleep_i = 1'b0;
    rchk(ESC_CAN_TRX_FLAGS_OFS, 8'h00);
    rchk(ESC_WAKE_FLAGS_OFS, 8'h04);
    final_report();
  end
endmodule
